//--- core/ccts_ctrl.sv
// CCP trigger, sync-output, output-steering and capture-gating control with Avalon-MM registers
`include "ccts_map.svh"
module ccts_ctrl #(
	parameter bit MULTI_OUT = 1'b1,
	parameter int OS_UNIT = 1
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic tb_period_match,
	input wire logic tb_rollover,
	input wire logic trig_out_event,
	input wire logic trig_in,
	input wire logic capture_mode,
	input wire logic timer_mode,
	input wire logic mode_aux_sig,
	input wire logic compare_event,
	input wire logic alt_sync_sig,
	input wire logic [31:0] sync_inputs,
	input wire logic capture_input_pin,
	input wire logic [2:0] comparator_out,
	input wire logic logic_cell_one,
	input wire logic logic_cell_two,
	input wire logic gating_src,
	output logic sync_out,
	output logic sync_src_sel,
	output logic tb_restart,
	output logic trigger_active,
	output logic clk_src_restrict,
	output logic [5:0] output_steer_enable,
	output logic capture_strobe,
	output logic capture_disable_flag,
	output logic aux_out,
	output logic cap_buffer_ovf,
	output logic irq
);
	logic [15:0] con1_r;
	logic [15:0] con2_r;
	logic [2:0] one_shot_count_r;
	logic [`CCTS_ST_W-1:0] stat_r;
	logic [`CCTS_ST_W-1:0] ien_r;
	logic [5:0] oe_live_r;
	logic [3:0] post_cnt_r;
	logic [2:0] cap_cnt_r;
	logic cap_src_d_r;
	logic gate_d_r;
	logic [5:0] os_cnt_r;
	ccts_pkg::ccts_bus_e bus_st_r;
	logic [15:0] c2_mask;
	logic wr_hit;
	logic post_evt;
	logic post_fire;
	logic cap_src;
	logic cap_edge;
	logic cap_fire;
	logic ovf_evt;
	logic trig_evt;
	logic [`CCTS_ST_W-1:0] stat_set;
	ccts_pkg::ccts_gate_e gsm;
	ccts_pkg::ccts_aux_e aux_sel;
	localparam logic [15:0] C1_MASK = `CCTS_C1_MASK;

	assign c2_mask = MULTI_OUT ? `CCTS_C2_MASK : `CCTS_C2_MASK_SINGLE;
	assign gsm = ccts_pkg::ccts_gate_e'(con2_r[`CCTS_C2_GSM_LSB +: 2]);
	assign aux_sel = ccts_pkg::ccts_aux_e'(con2_r[`CCTS_C2_AUX_LSB +: 2]);
	assign wr_hit = avs_write && bus_st_r == ccts_pkg::CCTS_BUS_IDLE;

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle per access keeps read data registered
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_st_r <= ccts_pkg::CCTS_BUS_IDLE;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= 1'b1;
			unique case (bus_st_r)
				ccts_pkg::CCTS_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_st_r <= ccts_pkg::CCTS_BUS_DONE;
						avs_waitrequest <= 1'b0;
						unique case (avs_address)
							`CCTS_CON1H_ADDR: avs_readdata <= {16'h0000, con1_r};
							`CCTS_CON2H_ADDR: avs_readdata <= {16'h0000, con2_r};
							`CCTS_STAT_ADDR: avs_readdata <= {29'h0, stat_r};
							`CCTS_IEN_ADDR: avs_readdata <= {29'h0, ien_r};
							default: avs_readdata <= 32'h0000_0000;
						endcase
					end
				end
				ccts_pkg::CCTS_BUS_DONE: bus_st_r <= ccts_pkg::CCTS_BUS_IDLE;
			endcase
		end
	end

	// Control registers; byte lanes honoured, masks keep unimplemented bits zero
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			con1_r <= `CCTS_CON_RST;
			con2_r <= `CCTS_CON_RST;
		end else if (wr_hit) begin
			if (avs_address == `CCTS_CON1H_ADDR) begin
				if (avs_byteenable[0]) con1_r[7:0] <= avs_writedata[7:0] & C1_MASK[7:0];
				if (avs_byteenable[1]) con1_r[15:8] <= avs_writedata[15:8] & C1_MASK[15:8];
			end
			if (avs_address == `CCTS_CON2H_ADDR) begin
				if (avs_byteenable[0]) con2_r[7:0] <= avs_writedata[7:0] & c2_mask[7:0];
				if (avs_byteenable[1]) con2_r[15:8] <= avs_writedata[15:8] & c2_mask[15:8];
			end
		end
	end

	// One-shot count field lives in the upper half of control two word
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			one_shot_count_r <= 3'h0;
		end else if (wr_hit && avs_address == `CCTS_CON2H_ADDR && avs_byteenable[2]) begin
			one_shot_count_r <= avs_writedata[18:16];
		end
	end

	// Interrupt enable register
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ien_r <= 3'h0;
		end else if (wr_hit && avs_address == `CCTS_IEN_ADDR) begin
			ien_r <= avs_writedata[`CCTS_ST_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Postscaler: source choice ignored when capturing
	assign post_evt = capture_mode ? 1'b0 :
		(con1_r[`CCTS_C1_PSSRC] ? trig_out_event : tb_period_match);
	assign post_fire = post_evt && post_cnt_r == con1_r[`CCTS_C1_PSC_LSB +: 4];
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			post_cnt_r <= 4'h0;
		end else if (capture_mode) begin
			post_cnt_r <= 4'h0;
		end else if (post_evt) begin
			post_cnt_r <= post_fire ? 4'h0 : post_cnt_r + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Capture source mux; unused codes select nothing
	always_comb begin
		unique case (con2_r[`CCTS_C2_CAP_SRC_LSB +: 3])
			3'h0: cap_src = capture_input_pin;
			3'h1: cap_src = comparator_out[0];
			3'h2: cap_src = comparator_out[1];
			3'h3: cap_src = comparator_out[2];
			3'h5: cap_src = logic_cell_one;
			3'h6: cap_src = logic_cell_two;
			default: cap_src = 1'b0;
		endcase
	end
	assign cap_edge = cap_src && !cap_src_d_r && capture_mode && !capture_disable_flag;
	// Beyond four held captures the buffer overflows rather than interrupting
	assign cap_fire = cap_edge && con1_r[11:10] == 2'b00 &&
		cap_cnt_r == {1'b0, con1_r[9:8]};
	assign ovf_evt = cap_edge && con1_r[11:10] != 2'b00 &&
		cap_cnt_r == 3'(`CCTS_CAP_DEPTH);
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cap_src_d_r <= 1'b0;
			cap_cnt_r <= 3'h0;
			capture_strobe <= 1'b0;
		end else begin
			cap_src_d_r <= cap_src;
			capture_strobe <= cap_edge;
			if (!capture_mode || cap_fire) cap_cnt_r <= 3'h0;
			else if (cap_edge && cap_cnt_r != 3'(`CCTS_CAP_DEPTH)) cap_cnt_r <= cap_cnt_r + 3'h1;
		end
	end

	// Gating: level follows, or edge sets/clears the disable flag
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gate_d_r <= 1'b0;
			capture_disable_flag <= 1'b0;
		end else begin
			gate_d_r <= gating_src;
			unique case (gsm)
				ccts_pkg::CCTS_GATE_LEVEL: capture_disable_flag <= !gating_src;
				ccts_pkg::CCTS_GATE_RISE:
					if (gating_src && !gate_d_r) capture_disable_flag <= 1'b0;
				ccts_pkg::CCTS_GATE_FALL:
					if (!gating_src && gate_d_r) capture_disable_flag <= 1'b1;
				ccts_pkg::CCTS_GATE_RSVD: capture_disable_flag <= capture_disable_flag;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Trigger, retrigger and one-shot duration
	assign trig_evt = con1_r[`CCTS_C1_TRIG_EN] && trig_in;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			trigger_active <= 1'b0;
			tb_restart <= 1'b0;
			os_cnt_r <= 6'h00;
			clk_src_restrict <= 1'b0;
		end else begin
			clk_src_restrict <= con1_r[`CCTS_C1_TRIG_EN];
			// Retrigger only applies when trigger already running
			tb_restart <= trig_evt && (!trigger_active || con1_r[`CCTS_C1_RTRG]);
			if (!con1_r[`CCTS_C1_TRIG_EN]) begin
				trigger_active <= 1'b0;
				os_cnt_r <= 6'h00;
			end else if (trig_evt && (!trigger_active || con1_r[`CCTS_C1_RTRG])) begin
				trigger_active <= 1'b1;
				os_cnt_r <= 6'({one_shot_count_r, 3'b000} + 6'(OS_UNIT));
			end else if (con1_r[`CCTS_C1_ONE_SHOT] && trigger_active && tb_rollover) begin
				if (os_cnt_r <= 6'(OS_UNIT)) trigger_active <= 1'b0;
				else os_cnt_r <= os_cnt_r - 6'(OS_UNIT);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync output, sync source pick and aux output
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_out <= 1'b0;
			sync_src_sel <= 1'b0;
			aux_out <= 1'b0;
		end else begin
			sync_out <= con1_r[`CCTS_C1_ALT_SYNC] ? alt_sync_sig : tb_rollover;
			sync_src_sel <= sync_inputs[con1_r[`CCTS_C1_SYNC_LSB +: 5]];
			unique case (aux_sel)
				ccts_pkg::CCTS_AUX_OFF: aux_out <= 1'b0;
				ccts_pkg::CCTS_AUX_ROLL: aux_out <= tb_rollover;
				ccts_pkg::CCTS_AUX_MODE: aux_out <= mode_aux_sig;
				ccts_pkg::CCTS_AUX_EVENT: aux_out <= !timer_mode && (cap_edge || compare_event);
			endcase
		end
	end

	// Output steering; synced mode waits for rollover to avoid mid-period glitches
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			oe_live_r <= 6'h00;
			output_steer_enable <= 6'h00;
		end else begin
			if (!con2_r[`CCTS_C2_OE_SYNC] || tb_rollover) begin
				oe_live_r <= con2_r[`CCTS_C2_OE_LSB +: 6];
			end
			output_steer_enable <= oe_live_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky status; a set in the clear cycle wins
	assign stat_set = {trig_evt, ovf_evt, post_fire || cap_fire};
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_r <= 3'h0;
			cap_buffer_ovf <= 1'b0;
			irq <= 1'b0;
		end else begin
			if (wr_hit && avs_address == `CCTS_STAT_ADDR)
				stat_r <= (stat_r & ~avs_writedata[`CCTS_ST_W-1:0]) | stat_set;
			else
				stat_r <= stat_r | stat_set;
			cap_buffer_ovf <= stat_r[`CCTS_ST_OVF];
			irq <= |(stat_r & ien_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_post_zero_each: assert property (@(posedge core_clk) disable iff (sys_rst)
		(post_evt && con1_r[11:8] == 4'h0) |-> post_fire) else $error("postscale 0 missed");
	a_src_select: assert property (@(posedge core_clk) disable iff (sys_rst)
		(!capture_mode && con1_r[15] && !trig_out_event) |-> !post_evt)
		else $error("postscale source wrong");
	a_cap_nopost: assert property (@(posedge core_clk) disable iff (sys_rst)
		capture_mode |-> !post_evt) else $error("postscale in capture");
	a_gate_level: assert property (@(posedge core_clk) disable iff (sys_rst)
		(gsm == ccts_pkg::CCTS_GATE_LEVEL) |=> capture_disable_flag == !$past(gating_src))
		else $error("level gating wrong");
	a_gate_fall: assert property (@(posedge core_clk) disable iff (sys_rst)
		(gsm == ccts_pkg::CCTS_GATE_FALL && gate_d_r && !gating_src) |=> capture_disable_flag)
		else $error("falling gate missed");
	a_restart_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		!con1_r[7] |=> !tb_restart) else $error("restart without trigger");
	a_oe_sync_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		(con2_r[15] && !tb_rollover) |=> $stable(oe_live_r)) else $error("oe changed early");
	a_single_oe: assert property (@(posedge core_clk) disable iff (sys_rst)
		!MULTI_OUT |-> con2_r[13:9] == 5'h00) else $error("bits B-F in single");
	a_unimpl_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
		con1_r[13:12] == 2'b00 && con2_r[14] == 1'b0 && con2_r[5] == 1'b0)
		else $error("unimplemented bit set");
	a_sync_out: assert property (@(posedge core_clk) disable iff (sys_rst)
		!con1_r[5] |=> sync_out == $past(tb_rollover)) else $error("sync out wrong");
	a_irq_level: assert property (@(posedge core_clk) disable iff (sys_rst)
		|(stat_r & ien_r) |=> irq) else $error("irq not raised");
	// Bus answers in exactly one cycle and never holds waitrequest low twice
	a_wait_answer: assert property (@(posedge core_clk) disable iff (sys_rst)
		(bus_st_r == ccts_pkg::CCTS_BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_one: assert property (@(posedge core_clk) disable iff (sys_rst)
		(bus_st_r == ccts_pkg::CCTS_BUS_DONE) |=> avs_waitrequest)
		else $error("wait low twice");
	// Trigger enable, restart and one-shot duration
	a_trig_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
		!con1_r[7] |=> !trigger_active) else $error("trigger active while off");
	a_clk_restrict: assert property (@(posedge core_clk) disable iff (sys_rst)
		con1_r[7] |=> clk_src_restrict) else $error("clock choice not restricted");
	a_first_start: assert property (@(posedge core_clk) disable iff (sys_rst)
		(trig_evt && !trigger_active) |=> tb_restart) else $error("first trigger lost");
	a_retrig_go: assert property (@(posedge core_clk) disable iff (sys_rst)
		(trig_evt && con1_r[14]) |=> tb_restart) else $error("retrigger lost");
	a_retrig_block: assert property (@(posedge core_clk) disable iff (sys_rst)
		(trig_evt && trigger_active && !con1_r[14]) |=> !tb_restart)
		else $error("retrigger while disabled");
	a_shot_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
		(con1_r[7] && !con1_r[6] && trigger_active) |=> trigger_active)
		else $error("trigger ended without one-shot");
	a_shot_end: assert property (@(posedge core_clk) disable iff (sys_rst)
		(con1_r[7] && con1_r[6] && trigger_active && tb_rollover && !trig_in &&
		os_cnt_r <= 6'(OS_UNIT)) |=> !trigger_active) else $error("one-shot overran");
	// Sync output, steering, aux selection, rising-edge gating and unused capture sources
	a_alt_sync: assert property (@(posedge core_clk) disable iff (sys_rst)
		con1_r[5] |=> sync_out == $past(alt_sync_sig)) else $error("alternate sync wrong");
	a_steer_follow: assert property (@(posedge core_clk) disable iff (sys_rst)
		1'b1 |=> output_steer_enable == $past(oe_live_r)) else $error("steering lags");
	a_gate_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
		(gsm == ccts_pkg::CCTS_GATE_RISE && gating_src && !gate_d_r) |=> !capture_disable_flag)
		else $error("rising gate missed");
	a_aux_off: assert property (@(posedge core_clk) disable iff (sys_rst)
		(aux_sel == ccts_pkg::CCTS_AUX_OFF) |=> !aux_out) else $error("aux active while off");
	a_aux_timer: assert property (@(posedge core_clk) disable iff (sys_rst)
		(aux_sel == ccts_pkg::CCTS_AUX_EVENT && timer_mode) |=> !aux_out)
		else $error("aux event in timer mode");
	a_cap_unused: assert property (@(posedge core_clk) disable iff (sys_rst)
		(con2_r[2:0] == 3'h4 || con2_r[2:0] == 3'h7) |-> !cap_src)
		else $error("unused source selected");
	// Status is sticky and a set beats a clear in the same cycle
	a_ovf_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
		ovf_evt |=> stat_r[`CCTS_ST_OVF]) else $error("overflow not flagged");
	a_set_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
		(stat_set != 3'h0) |=> (stat_r & $past(stat_set)) == $past(stat_set))
		else $error("status set lost");
	a_irq_low: assert property (@(posedge core_clk) disable iff (sys_rst)
		!(|(stat_r & ien_r)) |=> !irq) else $error("irq without enabled status");
	c_post_fire: cover property (@(posedge core_clk) post_fire && con1_r[11:8] == 4'hF);
	c_cap_ovf: cover property (@(posedge core_clk) ovf_evt);
	c_retrig: cover property (@(posedge core_clk) tb_restart && trigger_active);
	c_oe_sync: cover property (@(posedge core_clk) con2_r[15] && tb_rollover);
	c_shot_end: cover property (@(posedge core_clk) $fell(trigger_active) && con1_r[6]);
endmodule // ccts_ctrl

//--- core/ccts_map.svh
// Register offsets, field positions, reset values and capture buffer depth for the CCP control block
`ifndef CCTS_MAP_SVH
`define CCTS_MAP_SVH
// Byte addresses of the word registers on the bus
`define CCTS_CON1H_ADDR 4'h0
`define CCTS_CON2H_ADDR 4'h4
`define CCTS_STAT_ADDR 4'h8
`define CCTS_IEN_ADDR 4'hC
// Clear-register address, unused; status bits clear by writing ones at the status address
`define CCTS_ICLR_ADDR 4'h0
`define CCTS_ICLR_ADDR_HI 1'b1
// Control one high fields
`define CCTS_C1_PSSRC 15
`define CCTS_C1_RTRG 14
`define CCTS_C1_PSC_LSB 8
`define CCTS_C1_TRIG_EN 7
`define CCTS_C1_ONE_SHOT 6
`define CCTS_C1_ALT_SYNC 5
`define CCTS_C1_SYNC_LSB 0
// Implemented bit masks (unimplemented bits read as zero)
`define CCTS_C1_MASK 16'hCFFF
`define CCTS_C2_MASK 16'hBFDF
`define CCTS_C2_MASK_SINGLE 16'h81DF
// Control two high fields
`define CCTS_C2_OE_SYNC 15
`define CCTS_C2_OE_LSB 8
`define CCTS_C2_GSM_LSB 6
`define CCTS_C2_AUX_LSB 3
`define CCTS_C2_CAP_SRC_LSB 0
// Reset values
`define CCTS_CON_RST 16'h0000
// Status bit positions
`define CCTS_ST_IRQ 0
`define CCTS_ST_OVF 1
`define CCTS_ST_TRIG 2
`define CCTS_ST_W 3
// Capture buffer depth before overflow
`define CCTS_CAP_DEPTH 4
`endif

//--- core/ccts_pkg.sv
// Types shared by the CCP trigger, sync and output control block
package ccts_pkg;
	typedef enum logic [1:0] {
		CCTS_GATE_LEVEL,
		CCTS_GATE_RISE,
		CCTS_GATE_FALL,
		CCTS_GATE_RSVD
	} ccts_gate_e;
	typedef enum logic [1:0] {
		CCTS_AUX_OFF,
		CCTS_AUX_ROLL,
		CCTS_AUX_MODE,
		CCTS_AUX_EVENT
	} ccts_aux_e;
	typedef enum logic {
		CCTS_BUS_IDLE,
		CCTS_BUS_DONE
	} ccts_bus_e;
endpackage

//--- tb/ccts_ctrl_bench.sv
// Self-checking bench for the CCP trigger, sync and output control block
`include "ccts_map.svh"
module ccts_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] A1 = `CCTS_CON1H_ADDR;
	localparam logic [3:0] A2 = `CCTS_CON2H_ADDR;
	localparam logic [3:0] AS = `CCTS_STAT_ADDR;
	localparam logic [3:0] AE = `CCTS_IEN_ADDR;
	logic core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd, sync_inputs;
	logic [5:0] ev;
	logic [2:0] src_sel, cmp_out;
	logic capture_mode, timer_mode, mode_aux_sig, alt_sync_sig, gating_src, cap_pin, lc1, lc2;
	logic sync_out, sync_src_sel, tb_restart, trigger_active, clk_src_restrict;
	logic [5:0] steer;
	logic capture_strobe, capture_disable_flag, aux_out, cap_buffer_ovf, irq;
	int error_cnt, n_compared;
	////////////////////////////////////////////////////////////////////////
	ccts_ctrl ccts_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .tb_period_match(ev[0]), .tb_rollover(ev[1]),
		.trig_out_event(ev[2]), .trig_in(ev[3]), .capture_mode(capture_mode),
		.timer_mode(timer_mode), .mode_aux_sig(mode_aux_sig), .compare_event(ev[4]),
		.alt_sync_sig(alt_sync_sig), .sync_inputs(sync_inputs), .capture_input_pin(cap_pin),
		.comparator_out(cmp_out), .logic_cell_one(lc1), .logic_cell_two(lc2),
		.gating_src(gating_src), .sync_out(sync_out), .sync_src_sel(sync_src_sel),
		.tb_restart(tb_restart), .trigger_active(trigger_active),
		.clk_src_restrict(clk_src_restrict), .output_steer_enable(steer),
		.capture_strobe(capture_strobe), .capture_disable_flag(capture_disable_flag),
		.aux_out(aux_out), .cap_buffer_ovf(cap_buffer_ovf), .irq(irq));
	ccts_far_side ccts_far_side_i (.fire(ev[5]), .src_sel(src_sel), .capture_input_pin(cap_pin),
		.comparator_out(cmp_out), .logic_cell_one(lc1), .logic_cell_two(lc2));
	////////////////////////////////////////////////////////////////////////
	// Free-running 50 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// Compare and count; unknowns never match
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// One bus access; request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (avs_waitrequest !== 1'b0) begin
			error_cnt++;
			end_sim();
		end
	endtask
	task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	// One-cycle event pulse on input k
	task automatic pulse(input int k);
		@(posedge core_clk);
		ev[k] <= 1'b1;
		@(posedge core_clk);
		ev[k] <= 1'b0;
	endtask
	function automatic logic probe(input int k);
		case (k)
			0: return irq;
			1: return sync_out;
			2: return tb_restart;
			3: return capture_strobe;
			4: return aux_out;
			default: return cap_buffer_ovf;
		endcase
	endfunction
	// Short pulses are caught by OR-ing over a few cycles
	task automatic hit(input int k, input logic e);
		logic h;
		h = 1'b0;
		repeat (6) begin
			@(posedge core_clk);
			h = h | probe(k);
		end
		chk(h, e);
	endtask
	task automatic settle;
		repeat (3) @(posedge core_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		error_cnt = 0;
		n_compared = 0;
		sys_rst = 1'b1;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		{ev, src_sel, capture_mode, timer_mode, mode_aux_sig, alt_sync_sig, gating_src} = '0;
		sync_inputs = 32'h0;
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		rdchk(A1, 32'h0);
		rdchk(A2, 32'h0);
		bus(1'b1, A1, 32'h0000FFFF);
		rdchk(A1, 32'h0000CFFF);
		bus(1'b1, A2, 32'h0000FFFF);
		rdchk(A2, 32'h0000BFDF);
		bus(1'b1, 4'hA, 32'hFFFFFFFF);
		rdchk(4'hA, 32'h0);
		// Steering: immediate, then held until rollover
		bus(1'b1, A2, 32'h00003F00);
		settle();
		chk(steer, 6'h3F);
		bus(1'b1, A2, 32'h00008000);
		settle();
		chk(steer, 6'h3F);
		pulse(1);
		settle();
		chk(steer, 6'h00);
		// Sync output source and sync input select
		bus(1'b1, A2, 32'h0);
		bus(1'b1, A1, 32'h0005);
		pulse(1);
		hit(1, 1'b1);
		sync_inputs <= 32'h20;
		settle();
		chk(sync_src_sel, 1'b1);
		bus(1'b1, A1, 32'h0020);
		pulse(1);
		hit(1, 1'b0);
		alt_sync_sig <= 1'b1;
		hit(1, 1'b1);
		// Trigger and retrigger
		bus(1'b1, A1, 32'h4080);
		settle();
		chk(clk_src_restrict, 1'b1);
		pulse(3);
		hit(2, 1'b1);
		pulse(3);
		hit(2, 1'b1);
		bus(1'b1, A1, 32'h0080);
		pulse(3);
		hit(2, 1'b0);
		bus(1'b1, A1, 32'h4000);
		pulse(3);
		hit(2, 1'b0);
		// Postscale three, interrupt set, clear and mask
		bus(1'b1, AE, 32'h1);
		bus(1'b1, A1, 32'h0200);
		bus(1'b1, AS, 32'h7);
		repeat (2) pulse(0);
		bus(1'b0, AS, 32'h0);
		chk(rd[0], 1'b0);
		pulse(0);
		bus(1'b0, AS, 32'h0);
		chk(rd[0], 1'b1);
		chk(irq, 1'b1);
		bus(1'b1, AS, 32'h7);
		settle();
		chk(irq, 1'b0);
		bus(1'b1, AE, 32'h0);
		repeat (3) pulse(0);
		bus(1'b0, AS, 32'h0);
		chk(rd[0], 1'b1);
		chk(irq, 1'b0);
		// Postscaler counts trigger outputs instead of period matches
		bus(1'b1, A1, 32'h8000);
		bus(1'b1, AS, 32'h7);
		pulse(0);
		bus(1'b0, AS, 32'h0);
		chk(rd[0], 1'b0);
		pulse(2);
		bus(1'b0, AS, 32'h0);
		chk(rd[0], 1'b1);
		// Every capture source code, unused ones ignore all sources
		capture_mode <= 1'b1;
		gating_src <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, A2, 32'(i));
			src_sel <= 3'(i);
			pulse(5);
			hit(3, i != 4 && i != 7);
		end
		// Gating by level, then by edges
		bus(1'b1, A2, 32'h0);
		src_sel <= 3'h0;
		gating_src <= 1'b0;
		pulse(5);
		hit(3, 1'b0);
		bus(1'b1, A2, 32'h40);
		gating_src <= 1'b1;
		settle();
		chk(capture_disable_flag, 1'b0);
		bus(1'b1, A2, 32'h80);
		gating_src <= 1'b0;
		settle();
		chk(capture_disable_flag, 1'b1);
		gating_src <= 1'b1;
		// Capture postscale and buffer overflow
		bus(1'b1, A2, 32'h0);
		bus(1'b1, A1, 32'h0300);
		bus(1'b1, AS, 32'h7);
		repeat (3) pulse(5);
		bus(1'b0, AS, 32'h0);
		chk(rd[0], 1'b0);
		pulse(5);
		bus(1'b0, AS, 32'h0);
		chk(rd[0], 1'b1);
		bus(1'b1, A1, 32'h0400);
		repeat (5) pulse(5);
		hit(5, 1'b1);
		// Auxiliary output selection
		capture_mode <= 1'b0;
		bus(1'b1, A2, 32'h08);
		pulse(1);
		hit(4, 1'b1);
		bus(1'b1, A2, 32'h0);
		pulse(1);
		hit(4, 1'b0);
		timer_mode <= 1'b1;
		bus(1'b1, A2, 32'h18);
		pulse(4);
		hit(4, 1'b0);
		timer_mode <= 1'b0;
		pulse(4);
		hit(4, 1'b1);
		mode_aux_sig <= 1'b1;
		bus(1'b1, A2, 32'h10);
		hit(4, 1'b1);
		// One-shot with a zero count ends at the first rollover
		bus(1'b1, A1, 32'h00C0);
		pulse(3);
		settle();
		chk(trigger_active, 1'b1);
		pulse(1);
		settle();
		chk(trigger_active, 1'b0);
		end_sim();
	end
endmodule // ccts_ctrl_bench

//--- tb/ccts_far_side.sv
// Far-side model: capture pin, comparators and logic cells feeding the capture mux
module ccts_far_side (
	input wire logic fire,
	input wire logic [2:0] src_sel,
	output logic capture_input_pin,
	output logic [2:0] comparator_out,
	output logic logic_cell_one,
	output logic logic_cell_two
);
	timeunit 1ns;
	timeprecision 1ps;
	////////////////////////////////////////////////////////////////////////
	// Only the chosen source pulses; unused codes pulse all of them to expose leaks
	always_comb begin
		logic all_src;
		all_src = fire && (src_sel == 3'h4 || src_sel == 3'h7);
		capture_input_pin = all_src || (fire && src_sel == 3'h0);
		comparator_out[0] = all_src || (fire && src_sel == 3'h1);
		comparator_out[1] = all_src || (fire && src_sel == 3'h2);
		comparator_out[2] = all_src || (fire && src_sel == 3'h3);
		logic_cell_one = all_src || (fire && src_sel == 3'h5);
		logic_cell_two = all_src || (fire && src_sel == 3'h6);
	end
endmodule // ccts_far_side
